// file: hw/srcc_pkg.sv
// Package of constants and types for the sleep, reset and clock control block.
package srcc_pkg;

    // Reference clock period in picoseconds (20 MHz).
    localparam int unsigned REF_PERIOD_PS      = 50000;
    // Least reset hold after power-up or sleep end, in oscillator periods.
    localparam int unsigned RESET_HOLD_PERIODS = 24;
    // Oscillator period in picoseconds (24.576 MHz, about 40.69 ns).
    localparam int unsigned OSC24_PERIOD_PS    = 40690;
    // Least reset hold in reference cycles, rounded up.
    localparam int unsigned RESET_HOLD_CYCLES  =
        (RESET_HOLD_PERIODS * OSC24_PERIOD_PS + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
    // Divider ratio from the filter master clock (12.288 MHz) to the sub-band clock.
    localparam int unsigned SB_DIV_RATIO       = 2;
    // Number of bidirectional pins released during sleep.
    localparam int unsigned BIDIR_COUNT        = 7;
    // Number of ordinary frozen outputs.
    localparam int unsigned OUT_COUNT          = 8;
    // Width of the reset hold counter.
    localparam int unsigned HOLD_W             = 8;

    typedef enum logic [1:0] {
        SRCC_RESET = 2'b00,
        SRCC_RUN   = 2'b01,
        SRCC_SLEEP = 2'b10
    } srcc_state_t;

endpackage

// file: hw/srcc_pad_if.sv
// Interface carrying the pad-side data and enables between the top and the pad freezer.
`timescale 1ns/1ps
`default_nettype none
interface srcc_pad_if #(
    parameter int unsigned NO = 8,
    parameter int unsigned NB = 7
);
    logic [NO-1:0] out_core;
    logic [NO-1:0] out_pad;
    logic [NB-1:0] bidir_out_core;
    logic [NB-1:0] bidir_oe_core;
    logic [NB-1:0] bidir_out_pad;
    logic [NB-1:0] bidir_oe_pad;
    logic          sleeping;

    modport ctrl (
        output out_core,
        output bidir_out_core,
        output bidir_oe_core,
        output sleeping,
        input  out_pad,
        input  bidir_out_pad,
        input  bidir_oe_pad
    );
    modport pad (
        input  out_core,
        input  bidir_out_core,
        input  bidir_oe_core,
        input  sleeping,
        output out_pad,
        output bidir_out_pad,
        output bidir_oe_pad
    );
endinterface
`default_nettype wire

// file: hw/srcc_pad_freeze.sv
// Pad stage that freezes ordinary outputs and floats bidirectional pins during sleep.
`timescale 1ns/1ps
`default_nettype none
module srcc_pad_freeze (
    // Clock and reset
    input  wire logic REF_CLK,
    input  wire logic RST_N,
    // Pad carrier
    srcc_pad_if.pad   pads
);

    logic [$bits(pads.out_pad)-1:0]       out_hold;
    logic [$bits(pads.bidir_out_pad)-1:0] bidir_hold;

    // The last value before sleep is held, since the core keeps moving until it stops.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            out_hold   <= '0;
            bidir_hold <= '0;
        end else if (!pads.sleeping) begin
            out_hold   <= pads.out_core;
            bidir_hold <= pads.bidir_out_core;
        end
    end

    always_comb begin
        pads.out_pad       = pads.sleeping ? out_hold : pads.out_core;
        pads.bidir_out_pad = pads.sleeping ? bidir_hold : pads.bidir_out_core;
        pads.bidir_oe_pad  = pads.sleeping ? '0 : pads.bidir_oe_core;
    end

endmodule
`default_nettype wire

// file: hw/srcc_top.sv
// Top of the sleep, reset and clock control block.
// Notes on behaviour
// - Sleep high stops every internal clock.
// - Ordinary outputs hold their pre-sleep level.
// - Bidirectional pins float during sleep.
// - Sub-band master clock locked to filter clock.
`timescale 1ns/1ps
`default_nettype none
module srcc_top #(
    parameter int unsigned SB_DIV = srcc_pkg::SB_DIV_RATIO
) (
    // Clock and reset
    input  wire logic                              REF_CLK,
    input  wire logic                              RST_N,
    // Sleep and oscillator
    input  wire logic                              SLEEP_REQUEST,
    input  wire logic                              OSC_24M_CLOCK,
    input  wire logic                              FILTER_MASTER_CLOCK,
    // Core side
    input  wire logic [srcc_pkg::OUT_COUNT-1:0]    CORE_OUT,
    input  wire logic [srcc_pkg::BIDIR_COUNT-1:0]  CORE_BIDIR_OUT,
    input  wire logic [srcc_pkg::BIDIR_COUNT-1:0]  CORE_BIDIR_OE,
    // Pad side
    output logic      [srcc_pkg::OUT_COUNT-1:0]    PAD_OUT,
    output logic      [srcc_pkg::BIDIR_COUNT-1:0]  PAD_BIDIR_OUT,
    output logic      [srcc_pkg::BIDIR_COUNT-1:0]  PAD_BIDIR_OE,
    // Clock control
    output logic                                   CLOCK_ENABLE,
    output logic                                   SUBBAND_MASTER_CLOCK,
    output logic                                   CORE_RESET_N,
    output logic                                   RESET_TOO_SHORT
);

    srcc_pkg::srcc_state_t state;
    srcc_pkg::srcc_state_t next_state;
    logic [srcc_pkg::HOLD_W-1:0] hold_count;
    logic [7:0]                  div_count;
    logic                        fmc_prev;
    logic                        osc_prev;
    logic                        sleep_prev;
    logic                        reset_seen;
    logic                        in_reset;
    logic                        osc_rise;
    logic                        fmc_rise;

    localparam int unsigned   HW        = srcc_pkg::HOLD_W;
    localparam logic [HW-1:0] HOLD_STEP = HW'(1);
    localparam logic [HW-1:0] HOLD_MIN  = HW'(srcc_pkg::RESET_HOLD_PERIODS);
    localparam logic [7:0]    DIV_LAST  = 8'(SB_DIV / 2 - 1);

    function automatic logic is_asleep(input srcc_pkg::srcc_state_t st);
        return (st == srcc_pkg::SRCC_SLEEP);
    endfunction

    srcc_pad_if #(
        .NO (srcc_pkg::OUT_COUNT),
        .NB (srcc_pkg::BIDIR_COUNT)
    ) pads ();

    assign pads.out_core       = CORE_OUT;
    assign pads.bidir_out_core = CORE_BIDIR_OUT;
    assign pads.bidir_oe_core  = CORE_BIDIR_OE;
    assign pads.sleeping       = is_asleep(state);
    assign PAD_OUT             = pads.out_pad;
    assign PAD_BIDIR_OUT       = pads.bidir_out_pad;
    assign PAD_BIDIR_OE        = pads.bidir_oe_pad;
    assign osc_rise            = !osc_prev && OSC_24M_CLOCK;
    assign fmc_rise            = !fmc_prev && FILTER_MASTER_CLOCK;

    srcc_pad_freeze u_freeze (
        .REF_CLK (REF_CLK),
        .RST_N   (RST_N),
        .pads    (pads)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            srcc_pkg::SRCC_RESET: begin
                if (SLEEP_REQUEST) begin
                    next_state = srcc_pkg::SRCC_SLEEP;
                end else begin
                    next_state = srcc_pkg::SRCC_RUN;
                end
            end
            srcc_pkg::SRCC_RUN: begin
                if (SLEEP_REQUEST) begin
                    next_state = srcc_pkg::SRCC_SLEEP;
                end
            end
            srcc_pkg::SRCC_SLEEP: begin
                // Leaving sleep goes back through reset; only the outside reset frees the core reset.
                if (!SLEEP_REQUEST) begin
                    next_state = srcc_pkg::SRCC_RESET;
                end
            end
            default: next_state = srcc_pkg::SRCC_RESET;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state <= srcc_pkg::SRCC_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Core reset stays low after sleep until the outside reset has pulsed and released.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            reset_seen   <= 1'b1;
            CORE_RESET_N <= 1'b0;
        end else begin
            if (is_asleep(state)) begin
                reset_seen <= 1'b0;
            end
            CORE_RESET_N <= reset_seen && (state == srcc_pkg::SRCC_RUN);
        end
    end

    // Clocks stop one cycle after sleep is seen and restart one cycle after it ends.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            CLOCK_ENABLE <= 1'b0;
        end else begin
            CLOCK_ENABLE <= !SLEEP_REQUEST;
        end
    end

    // The oscillator level is tracked in and out of reset, so no rise is lost.
    always_ff @(posedge REF_CLK) begin
        osc_prev <= OSC_24M_CLOCK;
    end

    // Counts oscillator rises while reset is held; it saturates rather than wraps.
    always_ff @(posedge REF_CLK) begin
        if (RST_N) begin
            hold_count <= '0;
        end else if (osc_rise && (hold_count != '1)) begin
            hold_count <= hold_count + HOLD_STEP;
        end
    end

    always_ff @(posedge REF_CLK) begin
        in_reset <= !RST_N;
    end

    always_ff @(posedge REF_CLK) begin
        sleep_prev <= SLEEP_REQUEST;
    end

    // The counter powers up unknown, so the flag is only trustworthy from the second reset on.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            RESET_TOO_SHORT <= 1'b0;
        end else if (in_reset && (hold_count < HOLD_MIN)) begin
            RESET_TOO_SHORT <= 1'b1;
        end else if (sleep_prev && !SLEEP_REQUEST) begin
            RESET_TOO_SHORT <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            fmc_prev <= 1'b0;
        end else if (CLOCK_ENABLE) begin
            fmc_prev <= FILTER_MASTER_CLOCK;
        end
    end

    // Sub-band clock toggles on filter clock rises, so it stays frequency-locked.
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            div_count            <= 8'h00;
            SUBBAND_MASTER_CLOCK <= 1'b0;
        end else if (CLOCK_ENABLE && fmc_rise) begin
            if (div_count == DIV_LAST) begin
                div_count            <= 8'h00;
                SUBBAND_MASTER_CLOCK <= !SUBBAND_MASTER_CLOCK;
            end else begin
                div_count <= div_count + 8'h01;
            end
        end
    end

endmodule
`default_nettype wire

// file: test/srcc_top_asserts.sv
// Checker of the sleep, reset and clock control ports.
`timescale 1ns/1ps
`default_nettype none
module srcc_top_chk (
    // Clock and reset
    input wire logic       REF_CLK,
    input wire logic       RST_N,
    // Inputs
    input wire logic       SLEEP_REQUEST,
    input wire logic [7:0] CORE_OUT,
    input wire logic [6:0] CORE_BIDIR_OE,
    // Outputs
    input wire logic [7:0] PAD_OUT,
    input wire logic [6:0] PAD_BIDIR_OUT,
    input wire logic [6:0] PAD_BIDIR_OE,
    input wire logic       CLOCK_ENABLE,
    input wire logic       SUBBAND_MASTER_CLOCK,
    input wire logic       CORE_RESET_N
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    sequence slp2;
        SLEEP_REQUEST [*2];
    endsequence
    clk_stop_a: assert property (SLEEP_REQUEST |=> !CLOCK_ENABLE) else $error("clock on");
    clk_wake_a: assert property (!SLEEP_REQUEST |=> CLOCK_ENABLE) else $error("clock off");
    bd_float_a: assert property (SLEEP_REQUEST |=> PAD_BIDIR_OE == 7'h00) else $error("oe");
    pad_freeze_a: assert property (slp2 |-> $stable(PAD_OUT) && $stable(PAD_BIDIR_OUT))
        else $error("pad moved");
    pad_pass_a: assert property (!SLEEP_REQUEST [*2] |-> PAD_OUT == CORE_OUT
        && PAD_BIDIR_OE == CORE_BIDIR_OE) else $error("no pass");
    sb_stop_a: assert property (slp2 |=> $stable(SUBBAND_MASTER_CLOCK)) else $error("sb");
    wake_hold_a: assert property ($fell(SLEEP_REQUEST) |-> !CORE_RESET_N [*8])
        else $error("early run");
    run_start_a: assert property ($rose(RST_N) && !SLEEP_REQUEST |-> ##[1:2] CORE_RESET_N)
        else $error("no run");
    in_reset_a: assert property (disable iff (1'b0) !RST_N |=> !CORE_RESET_N && !CLOCK_ENABLE)
        else $error("reset");
endmodule
bind srcc_top srcc_top_chk i_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .SLEEP_REQUEST(SLEEP_REQUEST), .CORE_OUT(CORE_OUT), .CORE_BIDIR_OE(CORE_BIDIR_OE),
    .PAD_OUT(PAD_OUT), .PAD_BIDIR_OUT(PAD_BIDIR_OUT), .PAD_BIDIR_OE(PAD_BIDIR_OE),
    .CLOCK_ENABLE(CLOCK_ENABLE), .SUBBAND_MASTER_CLOCK(SUBBAND_MASTER_CLOCK),
    .CORE_RESET_N(CORE_RESET_N));
`default_nettype wire

// file: test/srcc_rst_src.sv
// Model of the outside reset source and power controller.
`timescale 1ns/1ps
`default_nettype none
module srcc_rst_src (
    // Clock
    input  wire logic       REF_CLK,
    // Bench controls
    input  wire logic       sleep,
    input  wire logic       kick,
    input  wire logic [7:0] hold,
    input  wire logic [7:0] lag,
    // Reset to the block
    output logic            RST_N
);
    // A late answer after sleep lets the bench see the core refused meanwhile.
    int   cnt     = 1;
    int   dly     = 0;
    logic sleep_d = 1'b0;
    logic rst_q   = 1'b0;
    assign RST_N = rst_q;
    always @(negedge REF_CLK) begin
        sleep_d <= sleep;
        if (kick || (sleep_d && !sleep)) begin
            dly <= int'(lag) + 1;
        end else if (dly != 0) begin
            dly <= dly - 1;
        end
        if (dly == 1) begin
            cnt <= int'(hold);
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
        rst_q <= (cnt == 0);
    end
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking testbench of the sleep, reset and clock control top.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clk = 1'b0, osc = 1'b0, fclk = 1'b0, sleep = 1'b0, kick = 1'b0;
    logic [7:0] hold = 8'h01, lag = 8'h00, c_out = 8'h00, pad_out;
    logic [6:0] bd_out = 7'h00, bd_oe = 7'h00, pbd_out, pbd_oe;
    logic       rst_n, ce, smc, crst_n, short;
    int         failures = 0, checks = 0, cycles = 0;
    srcc_top #(.SB_DIV(2)) i_srcc_top (.REF_CLK(clk), .RST_N(rst_n), .SLEEP_REQUEST(sleep),
        .OSC_24M_CLOCK(osc), .FILTER_MASTER_CLOCK(fclk), .CORE_OUT(c_out),
        .CORE_BIDIR_OUT(bd_out), .CORE_BIDIR_OE(bd_oe), .PAD_OUT(pad_out),
        .PAD_BIDIR_OUT(pbd_out), .PAD_BIDIR_OE(pbd_oe), .CLOCK_ENABLE(ce),
        .SUBBAND_MASTER_CLOCK(smc), .CORE_RESET_N(crst_n), .RESET_TOO_SHORT(short));
    srcc_rst_src i_src (.REF_CLK(clk), .sleep(sleep), .kick(kick), .hold(hold), .lag(lag),
        .RST_N(rst_n));
    initial forever #25 clk = ~clk;
    always @(negedge clk) begin
        osc <= ~osc;
        fclk <= ~fclk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic t_power;
        repeat (4) @(negedge clk);
        cmp(crst_n, 1'b1);
        hold <= 8'd5;
        kick <= 1'b1;
        @(negedge clk);
        kick <= 1'b0;
        repeat (15) @(negedge clk);
        cmp(short, 1'b1);
        hold <= 8'd60;
        kick <= 1'b1;
        @(negedge clk);
        kick <= 1'b0;
        repeat (70) @(negedge clk);
        cmp(short, 1'b0);
        cmp(crst_n, 1'b1);
        $display("power test done");
    endtask
    task automatic t_subclk;
        int   rises, flips;
        logic f_d, s_d;
        rises = 0;
        flips = 0;
        f_d = fclk;
        s_d = smc;
        repeat (64) begin
            @(posedge clk);
            if (fclk && !f_d) rises++;
            if (smc != s_d) flips++;
            f_d = fclk;
            s_d = smc;
        end
        // The divider is free-running, so one edge of phase slack is allowed.
        cmp(8'(flips + 1 >= rises && flips <= rises + 1), 8'h01);
        $display("sub-band clock test done");
    endtask
    task automatic t_sleep;
        logic s0;
        @(negedge clk);
        c_out <= 8'ha5;
        bd_out <= 7'h55;
        bd_oe <= 7'h7f;
        lag <= 8'd10;
        hold <= 8'd60;
        @(negedge clk);
        sleep <= 1'b1;
        @(negedge clk);
        c_out <= 8'h3c;
        bd_out <= 7'h2a;
        @(negedge clk);
        s0 = smc;
        repeat (10) @(negedge clk);
        cmp(pad_out, 8'ha5);
        cmp(pbd_out, 7'h55);
        cmp(pbd_oe, 7'h00);
        cmp(ce, 1'b0);
        cmp(smc, s0);
        sleep <= 1'b0;
        repeat (5) @(negedge clk);
        cmp(crst_n, 1'b0);
        cmp(ce, 1'b1);
        cmp(pad_out, 8'h3c);
        cmp(pbd_oe, 7'h7f);
        repeat (75) @(negedge clk);
        cmp(crst_n, 1'b1);
        cmp(short, 1'b0);
        $display("sleep test done");
    endtask
    task automatic final_report;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        t_power();
        t_subclk();
        t_sleep();
        final_report();
    end
endmodule
`default_nettype wire
